// ### src/dsrc_pkg.sv
package dsrc_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] DSRC_CTRL_OFF = 8'h00;
  localparam logic [7:0] DSRC_STAT_OFF = 8'h04;
  localparam logic [7:0] DSRC_QPTR_OFF = 8'h10;
  localparam int DSRC_FLOW_BIT = 0;
  localparam int DSRC_SORT_BIT = 1;
  localparam int DSRC_THR_LSB = 8;
  localparam logic [31:0] DSRC_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] DSRC_QPTR_RST = 32'h0000_0000;
  localparam logic [31:0] DSRC_DESC_STEP = 32'h0000_0008;
  localparam logic [31:0] DSRC_WORD_STEP = 32'h0000_0004;

  // ---------------------------------------------------------------
  // Indicate status codes
  // ---------------------------------------------------------------
  localparam logic [3:0] IS_LAST_PCROSS = 4'h0;
  localparam logic [3:0] IS_PCROSS = 4'h1;
  localparam logic [3:0] IS_HDR_END = 4'h2;
  localparam logic [3:0] IS_PCROSS_HDR = 4'h3;
  localparam logic [3:0] IS_INTERMED = 4'h4;
  localparam logic [3:0] IS_BURST = 4'h5;
  localparam logic [3:0] IS_THRESH = 4'h6;
  localparam logic [3:0] IS_SVC_OPP = 4'h7;
  localparam logic [3:0] IS_NO_DATA = 4'h8;
  localparam logic [3:0] IS_NO_HDR = 4'h9;
  localparam logic [3:0] IS_HDR_ONLY = 4'ha;
  localparam logic [3:0] IS_NO_INFO = 4'hb;
  localparam logic [3:0] IS_OVERRUN = 4'hc;
  localparam logic [3:0] IS_BAD_FRAME = 4'hd;
  localparam logic [3:0] IS_PARITY = 4'he;
  localparam logic [3:0] IS_INTERNAL = 4'hf;

  // Part tags
  localparam logic [1:0] TAG_MIDDLE = 2'b00;
  localparam logic [1:0] TAG_LAST = 2'b01;
  localparam logic [1:0] TAG_FIRST = 2'b10;
  localparam logic [1:0] TAG_ONLY = 2'b11;

  localparam logic [1:0] THIRD_INDICATE_CHANNEL = 2'h2;

  // Transmit descriptor exception codes
  localparam logic [3:0] EXC_NONE = 4'h0;
  localparam logic [3:0] EXC_CONF_CLASS = 4'h1;
  localparam logic [3:0] EXC_REQ_CLASS = 4'h2;
  localparam logic [3:0] EXC_FIRST_OPEN = 4'h3;
  localparam logic [3:0] EXC_NOT_FIRST = 4'h4;

  // Receive unit completion event
  typedef struct packed {
    logic [1:0] indicate_channel;
    logic [1:0] tag;
    logic page_cross;
    logic queue_last;
    logic header_end;
    logic frame_end;
    logic burst_bnd;
    logic svc_token;
    logic ring_reset_event;
    logic mac_frame;
    logic ring_op_change;
    logic no_data_space;
    logic no_header_space;
    logic no_unit_space;
    logic hdr_copied;
    logic info_started;
    logic fifo_overrun;
    logic bad_length;
    logic bad_fcs;
    logic parity_err;
    logic internal_err;
  } dsrc_rx_unit_t;

  // Parameters of one transmit job object
  typedef struct packed {
    logic [7:0] fc;
    logic [3:0] rqcls;
    logic [3:0] cnfcls;
    logic [3:0] uid;
  } dsrc_job_t;

  // One transmit descriptor part
  typedef struct packed {
    logic [1:0] tag;
    logic [7:0] size;
    logic [27:0] loc;
  } dsrc_part_t;

endpackage

// ### src/dsrc_top.sv
// The register offsets and the Wishbone register port were chosen for this implementation.
`timescale 1ns/100ps
// What this block does
// - Last queue slot with page cross pending writes 0000 and drops rest.
// - Code 0000 never goes into a middle-part descriptor.
// - Code 0001 marks a page cross, only on first or middle parts.
// - Header end writes 0010; header end with page cross writes 0011.
// - Normal end without breakpoint writes 0100.
// - Normal end with burst boundary breakpoint writes 0101.
// - Copied-frame threshold counter reaching its limit writes 0110.
// - Token, ring reset, MAC frame or ring-op change before end writes 0111.
// - Partial copy for lack of data space writes 1000, sorting off only.
// - Sorting on and no header space aborts copy, writes 1001.
// - Header fits but no data or third-channel descriptor space writes 1010.
// - Header copied, space ran out during info writes 1011.
// - Receive FIFO overrun writes 1100; software discards the frame.
// - Bad length or bad frame check sequence writes 1101.
// - Parity error writes 1110, checked only with parity flow enable set.
// - Internal receive fault writes 1111; software resets the device.
// - Job object parameters come from its first part only.
// - Each transmit part is fetched at the channel queue pointer.
// - One job object per channel per service opportunity.
// - First part with bad confirmation class or request class 0 is inconsistent.
// - First part after an unfinished object is inconsistent.
// - Non-first, non-single part after a finished object is inconsistent.
// - Inconsistency aborts the job and reports in completion status.
// - Part tags: 10 first, 00 middle, 01 last, 11 single.
module dsrc_top #(
  parameter int NUM_TX_CH = 2,
  parameter int THR_W = 8,
  parameter logic [15:0] CONF_CLASS_MASK = 16'hffff
) (
  // System clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Receive unit completion
  input wire logic rx_valid_i,
  input wire dsrc_pkg::dsrc_rx_unit_t rx_unit_i,
  output logic unit_desc_valid_o,
  output logic [3:0] indicate_status_field_o,
  output logic [1:0] unit_desc_tag_o,
  output logic rx_drop_o,
  // Transmit service opportunity
  input wire logic svc_i,
  input wire logic [$clog2(NUM_TX_CH)-1:0] svc_ch_i,
  output logic svc_busy_o,
  // Descriptor memory read port
  output logic mem_req_o,
  output logic [31:0] mem_addr_o,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_data_i,
  // Transmit results
  output logic part_valid_o,
  output dsrc_pkg::dsrc_part_t part_o,
  output dsrc_pkg::dsrc_job_t job_o,
  output logic job_done_o,
  output logic abort_o,
  output logic [3:0] completion_report_descriptor_status_o
);
  import dsrc_pkg::*;

  localparam int CH_W = $clog2(NUM_TX_CH);

  typedef enum logic [1:0] {
    DSRC_IDLE,
    DSRC_WORD0,
    DSRC_WORD1,
    DSRC_CHECK
  } dsrc_state_t;

  logic [31:0] ctrl;
  logic [31:0] qptr [NUM_TX_CH];
  logic [THR_W-1:0] thr_cnt;
  logic [3:0] last_exc;
  dsrc_state_t state;
  logic [CH_W-1:0] cur_ch;
  logic [31:0] word0;
  logic [NUM_TX_CH-1:0] prev_end;
  logic wb_hit;
  logic [31:0] next_rdata;
  logic [3:0] next_is;
  logic [1:0] next_tag;
  logic next_drop;
  logic thr_hit;
  logic normal_end;
  logic flow_en;
  logic sort_en;
  logic [THR_W-1:0] thr_limit;
  logic [1:0] chk_tag;
  logic [3:0] next_exc;

  assign flow_en = ctrl[DSRC_FLOW_BIT];
  assign sort_en = ctrl[DSRC_SORT_BIT];
  assign thr_limit = ctrl[DSRC_THR_LSB +: THR_W];

  // ---------------------------------------------------------------
  // Wishbone slave
  // ---------------------------------------------------------------
  // Registered ack: every access costs exactly one wait cycle
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_hit;
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (wb_adr_i == DSRC_CTRL_OFF) begin
      next_rdata = ctrl;
    end else if (wb_adr_i == DSRC_STAT_OFF) begin
      next_rdata = {20'h00000, last_exc, thr_cnt[7:0] & 8'hff};
      next_rdata[31] = (state != DSRC_IDLE);
    end else begin
      for (int i = 0; i < NUM_TX_CH; i++) begin
        if (wb_adr_i == DSRC_QPTR_OFF + 8'(4 * i)) begin
          next_rdata = qptr[i];
        end
      end
    end
  end

  // Unmapped reads return zero, writes there are dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_hit && !wb_we_i) begin
      wb_dat_o <= next_rdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= DSRC_CTRL_RST;
    end else if (wb_hit && wb_we_i && wb_adr_i == DSRC_CTRL_OFF) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b]) begin
          ctrl[8*b +: 8] <= wb_dat_i[8*b +: 8];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Indicate status encoding
  // ---------------------------------------------------------------
  // Errors outrank space aborts, which outrank the normal-end codes
  assign normal_end = rx_unit_i.frame_end;
  assign thr_hit = normal_end && (thr_limit != '0) && (thr_cnt + 1'b1 == thr_limit);

  always_comb begin
    next_is = IS_INTERMED;
    next_tag = rx_unit_i.tag;
    next_drop = 1'b0;
    if (rx_unit_i.internal_err) begin
      next_is = IS_INTERNAL;
    end else if (flow_en && rx_unit_i.parity_err) begin
      next_is = IS_PARITY;
    end else if (rx_unit_i.bad_length || rx_unit_i.bad_fcs) begin
      next_is = IS_BAD_FRAME;
    end else if (rx_unit_i.fifo_overrun) begin
      next_is = IS_OVERRUN;
    end else if (!sort_en && rx_unit_i.no_data_space) begin
      next_is = IS_NO_DATA;
    end else if (sort_en && rx_unit_i.no_header_space) begin
      next_is = IS_NO_HDR;
    end else if (sort_en && rx_unit_i.hdr_copied && (rx_unit_i.no_data_space ||
                 (rx_unit_i.indicate_channel == THIRD_INDICATE_CHANNEL &&
                  rx_unit_i.no_unit_space))) begin
      if (rx_unit_i.info_started) begin
        next_is = IS_NO_INFO;
      end else begin
        next_is = IS_HDR_ONLY;
      end
    end else if (rx_unit_i.queue_last && rx_unit_i.page_cross) begin
      next_is = IS_LAST_PCROSS;
      next_drop = 1'b1;
      // Never a middle part, so zero status plus zero tag stays a null
      if (rx_unit_i.tag == TAG_MIDDLE) begin
        next_tag = TAG_LAST;
      end
    end else if (normal_end) begin
      if (rx_unit_i.svc_token || rx_unit_i.ring_reset_event ||
          rx_unit_i.mac_frame || rx_unit_i.ring_op_change) begin
        next_is = IS_SVC_OPP;
      end else if (rx_unit_i.burst_bnd) begin
        next_is = IS_BURST;
      end else if (thr_hit) begin
        next_is = IS_THRESH;
      end else begin
        next_is = IS_INTERMED;
      end
    end else if (rx_unit_i.header_end) begin
      next_is = rx_unit_i.page_cross ? IS_PCROSS_HDR : IS_HDR_END;
    end else if (rx_unit_i.page_cross) begin
      next_is = IS_PCROSS;
      // A page cross always continues, so it cannot close the object
      if (rx_unit_i.tag == TAG_ONLY) begin
        next_tag = TAG_FIRST;
      end else if (rx_unit_i.tag == TAG_LAST) begin
        next_tag = TAG_MIDDLE;
      end
    end
  end

  // One code per completed unit, registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      unit_desc_valid_o <= 1'b0;
      indicate_status_field_o <= IS_LAST_PCROSS;
      unit_desc_tag_o <= TAG_MIDDLE;
      rx_drop_o <= 1'b0;
    end else begin
      unit_desc_valid_o <= rx_valid_i;
      rx_drop_o <= rx_valid_i && next_drop;
      if (rx_valid_i) begin
        indicate_status_field_o <= next_is;
        unit_desc_tag_o <= next_tag;
      end
    end
  end

  // Counts normally ended frames; restarts at the limit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      thr_cnt <= '0;
    end else if (rx_valid_i && normal_end && next_is[3:2] == 2'b01) begin
      thr_cnt <= thr_hit ? '0 : thr_cnt + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Transmit descriptor fetch and check
  // ---------------------------------------------------------------
  // Tag is judged as the second word arrives; the classes come from
  // the first word, latched one answer earlier
  assign chk_tag = mem_data_i[31:30];

  always_comb begin
    next_exc = EXC_NONE;
    if (chk_tag == TAG_FIRST || chk_tag == TAG_ONLY) begin
      if (!CONF_CLASS_MASK[word0[15:12]]) begin
        next_exc = EXC_CONF_CLASS;
      end else if (word0[11:8] == 4'h0) begin
        next_exc = EXC_REQ_CLASS;
      end else if (chk_tag == TAG_FIRST && !prev_end[cur_ch]) begin
        next_exc = EXC_FIRST_OPEN;
      end
    end else if (prev_end[cur_ch]) begin
      next_exc = EXC_NOT_FIRST;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= DSRC_IDLE;
      cur_ch <= '0;
      word0 <= 32'h0000_0000;
    end else begin
      case (state)
        DSRC_IDLE: begin
          if (svc_i) begin
            cur_ch <= svc_ch_i;
            state <= DSRC_WORD0;
          end
        end
        DSRC_WORD0: begin
          if (mem_ack_i) begin
            word0 <= mem_data_i;
            state <= DSRC_WORD1;
          end
        end
        DSRC_WORD1: begin
          if (mem_ack_i) begin
            // Object ends on a last or single part, or on an abort
            if (next_exc != EXC_NONE || chk_tag[0]) begin
              state <= DSRC_CHECK;
            end else begin
              state <= DSRC_WORD0;
            end
          end
        end
        DSRC_CHECK: begin
          state <= DSRC_IDLE;
        end
        default: begin
          state <= DSRC_IDLE;
        end
      endcase
    end
  end

  // Request and address hold until the answer, so slow memory is safe
  assign svc_busy_o = (state != DSRC_IDLE);
  assign mem_req_o = (state == DSRC_WORD0) || (state == DSRC_WORD1);

  always_comb begin
    mem_addr_o = qptr[cur_ch];
    if (state == DSRC_WORD1) begin
      mem_addr_o = qptr[cur_ch] + DSRC_WORD_STEP;
    end
  end

  // Queue pointers: software loads, fetch advances past each part
  generate
    for (genvar g = 0; g < NUM_TX_CH; g++) begin : g_qptr
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          qptr[g] <= DSRC_QPTR_RST;
        end else if (state == DSRC_WORD1 && mem_ack_i && cur_ch == CH_W'(g)) begin
          qptr[g] <= qptr[g] + DSRC_DESC_STEP;
        end else if (wb_hit && wb_we_i && wb_adr_i == DSRC_QPTR_OFF + 8'(4 * g)) begin
          qptr[g] <= wb_dat_i;
        end
      end

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          prev_end[g] <= 1'b1;
        end else if (state == DSRC_WORD1 && mem_ack_i && cur_ch == CH_W'(g)) begin
          // An aborted object is closed so the next one starts clean
          prev_end[g] <= chk_tag[0] || (next_exc != EXC_NONE);
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      part_valid_o <= 1'b0;
      part_o <= '0;
      job_o <= '0;
      job_done_o <= 1'b0;
      abort_o <= 1'b0;
      completion_report_descriptor_status_o <= EXC_NONE;
      last_exc <= EXC_NONE;
    end else begin
      part_valid_o <= 1'b0;
      job_done_o <= 1'b0;
      abort_o <= 1'b0;
      if (state == DSRC_WORD1 && mem_ack_i) begin
        if (next_exc != EXC_NONE) begin
          abort_o <= 1'b1;
          completion_report_descriptor_status_o <= next_exc;
          last_exc <= next_exc;
        end else begin
          part_valid_o <= 1'b1;
          part_o <= {chk_tag, word0[23:16], mem_data_i[27:0]};
          if (chk_tag[1]) begin
            job_o <= {word0[7:0], word0[11:8], word0[15:12], word0[27:24]};
          end
          if (chk_tag[0]) begin
            job_done_o <= 1'b1;
            completion_report_descriptor_status_o <= EXC_NONE;
          end
        end
      end
    end
  end

endmodule

// ### dv/dsrc_sva.sv
`timescale 1ns/100ps
module dsrc_sva (
  // Clock, reset, bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Receive
  input wire logic rx_valid_i,
  input wire dsrc_pkg::dsrc_rx_unit_t rx_unit_i,
  input wire logic unit_desc_valid_o,
  input wire logic [3:0] indicate_status_field_o,
  input wire logic [1:0] unit_desc_tag_o,
  input wire logic rx_drop_o,
  // Transmit
  input wire logic svc_i,
  input wire logic svc_busy_o,
  input wire logic mem_req_o,
  input wire logic [31:0] mem_addr_o,
  input wire logic mem_ack_i,
  input wire logic job_done_o,
  input wire logic abort_o,
  input wire logic [3:0] completion_report_descriptor_status_o
);
  import dsrc_pkg::*;
  logic [3:0] st;
  logic hard;
  assign st = indicate_status_field_o;
  assign hard = rx_unit_i.internal_err | rx_unit_i.parity_err;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_RX_ONE: assert property (rx_valid_i |=> unit_desc_valid_o)
    else $error("unit without descriptor");
  AST_RX_QUIET: assert property (unit_desc_valid_o |-> $past(rx_valid_i))
    else $error("descriptor without unit");
  AST_INTERNAL: assert property (
    rx_valid_i && rx_unit_i.internal_err |=> st == IS_INTERNAL)
    else $error("internal fault code wrong");
  AST_BAD: assert property (
    rx_valid_i && !hard && rx_unit_i.bad_fcs |=> st == IS_BAD_FRAME)
    else $error("bad frame code wrong");
  AST_NULL_DESC: assert property (
    unit_desc_valid_o && st == IS_LAST_PCROSS |-> unit_desc_tag_o != TAG_MIDDLE && rx_drop_o)
    else $error("zero code on middle part");
  AST_DROP: assert property (rx_drop_o |-> unit_desc_valid_o && st == IS_LAST_PCROSS)
    else $error("drop without zero code");
  AST_PCROSS_TAG: assert property (
    unit_desc_valid_o && st == IS_PCROSS |-> unit_desc_tag_o[0] == 1'b0)
    else $error("page cross on last or single part");
  AST_HOLD: assert property (
    mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o))
    else $error("fetch dropped before answer");
  AST_START: assert property (svc_i && !svc_busy_o |=> mem_req_o && svc_busy_o)
    else $error("opportunity not served");
  AST_ONE_OBJ: assert property (job_done_o || abort_o |-> !mem_req_o [*2])
    else $error("fetch past end of object");
  AST_ABORT: assert property (
    abort_o |-> completion_report_descriptor_status_o inside {[1:4]})
    else $error("abort without exception");
  AST_WB_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer wrong");
  cover property (rx_drop_o);
  cover property (unit_desc_valid_o && st == IS_THRESH);
  cover property (abort_o);
  cover property (job_done_o);
endmodule

bind dsrc_top dsrc_sva i_sva (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .rx_valid_i,
  .rx_unit_i, .unit_desc_valid_o, .indicate_status_field_o, .unit_desc_tag_o, .rx_drop_o, .svc_i,
  .svc_busy_o, .mem_req_o, .mem_addr_o, .mem_ack_i, .job_done_o, .abort_o,
  .completion_report_descriptor_status_o);

// ### dv/dsrc_mem_model.sv
`timescale 1ns/100ps
module dsrc_mem_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Descriptor read port
  input wire logic mem_req_i,
  input wire logic [31:0] mem_addr_i,
  input wire logic [1:0] lat_i,
  output logic mem_ack_o,
  output logic [31:0] mem_data_o
);
  logic [31:0] mem [64];
  logic [1:0] wait_cnt;
  // Data flips outside an answer, so a stale word never looks valid
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_ack_o <= 1'b0;
      wait_cnt <= 2'h0;
      mem_data_o <= 32'h5a5a_5a5a;
    end else if (mem_ack_o || !mem_req_i || wait_cnt != lat_i) begin
      mem_ack_o <= 1'b0;
      wait_cnt <= (mem_req_i && !mem_ack_o) ? wait_cnt + 2'h1 : 2'h0;
      mem_data_o <= ~mem_data_o;
    end else begin
      mem_ack_o <= 1'b1;
      wait_cnt <= 2'h0;
      mem_data_o <= mem[mem_addr_i[7:2]];
    end
  end
endmodule

// ### dv/tb_dsrc_top.sv
`timescale 1ns/100ps
module tb_dsrc_top;
  import dsrc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, rx_valid_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, mem_addr_o, mem_data_i, rd, x;
  logic [31:0] seed = 32'h2d;
  logic wb_ack_o, unit_desc_valid_o, rx_drop_o, svc_i = 1'b0, svc_ch_i = 1'b0;
  logic svc_busy_o, mem_req_o, mem_ack_i, part_valid_o, job_done_o, abort_o;
  logic [3:0] indicate_status_field_o, completion_report_descriptor_status_o;
  logic [1:0] unit_desc_tag_o, lat = 2'h0;
  logic flow = 1'b0, sort = 1'b0;
  dsrc_rx_unit_t rx_unit_i = '0, u;
  dsrc_part_t part_o;
  dsrc_job_t job_o;
  int error_cnt = 0, checked = 0, fcnt = 0, thr = 0;
  logic [7:0] rxq[$];
  logic [23:0] txq[$];

  always #4 clk_i = ~clk_i;

  dsrc_top #(.CONF_CLASS_MASK(16'hfffe)) i_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o, .rx_valid_i, .rx_unit_i,
    .unit_desc_valid_o, .indicate_status_field_o, .unit_desc_tag_o, .rx_drop_o, .svc_i,
    .svc_ch_i,
    .svc_busy_o, .mem_req_o, .mem_addr_o, .mem_ack_i, .mem_data_i, .part_valid_o, .part_o,
    .job_o, .job_done_o, .abort_o, .completion_report_descriptor_status_o);
  dsrc_mem_model i_mem (.clk_i, .rst_i, .mem_req_i(mem_req_o), .mem_addr_i(mem_addr_o),
    .lat_i(lat), .mem_ack_o(mem_ack_i), .mem_data_o(mem_data_i));

  // ----
  // Helpers
  // ----
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic test_done();
    if (error_cnt == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1);
    chk("wb_ack_lat", 2, n);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  function automatic logic [3:0] ref_code(input dsrc_rx_unit_t v);
    if (v.internal_err) return IS_INTERNAL;
    if (flow && v.parity_err) return IS_PARITY;
    if (v.bad_length || v.bad_fcs) return IS_BAD_FRAME;
    if (v.fifo_overrun) return IS_OVERRUN;
    if (!sort && v.no_data_space) return IS_NO_DATA;
    if (sort && v.no_header_space) return IS_NO_HDR;
    if (sort && v.hdr_copied && (v.no_data_space ||
        v.indicate_channel == THIRD_INDICATE_CHANNEL && v.no_unit_space))
      return v.info_started ? IS_NO_INFO : IS_HDR_ONLY;
    if (v.queue_last && v.page_cross) return IS_LAST_PCROSS;
    if (v.frame_end && (v.svc_token | v.ring_reset_event | v.mac_frame | v.ring_op_change))
      return IS_SVC_OPP;
    if (v.frame_end && v.burst_bnd) return IS_BURST;
    if (v.frame_end || !v.header_end && !v.page_cross) return IS_INTERMED;
    if (v.header_end) return v.page_cross ? IS_PCROSS_HDR : IS_HDR_END;
    return IS_PCROSS;
  endfunction

  task automatic rx(input dsrc_rx_unit_t v);
    logic [3:0] c;
    logic [1:0] t;
    c = ref_code(v);
    t = v.tag;
    if (v.frame_end && c[3:2] == 2'b01) fcnt++;
    if (thr != 0 && fcnt == thr) begin
      if (c == IS_INTERMED) c = IS_THRESH;
      fcnt = 0;
    end
    if (c == IS_PCROSS) t = (t == TAG_ONLY) ? TAG_FIRST : (t == TAG_LAST) ? TAG_MIDDLE : t;
    if (c == IS_LAST_PCROSS && t == TAG_MIDDLE) t = TAG_LAST;
    rxq.push_back({1'b1, c == IS_LAST_PCROSS, t, c});
    rx_valid_i <= 1'b1;
    rx_unit_i <= v;
    @(posedge clk_i);
  endtask

  task automatic desc(input int i, input logic [1:0] tg, input logic [7:0] fc,
                      input logic [3:0] rq, input logic [3:0] cf);
    i_mem.mem[2 * i] = {8'h00, 8'h10, cf, rq, fc};
    i_mem.mem[2 * i + 1] = {tg, 22'h0, 8'(i)};
  endtask

  task automatic ex(input logic [3:0] ab_dn_tg, input logic [3:0] e, input int i,
                    input logic [7:0] fc);
    txq.push_back({ab_dn_tg, e, 8'(i), fc});
  endtask

  // Pulse is held for two cycles; the second lands while busy and must be ignored
  task automatic svc(input logic ch);
    int n = 0;
    lat <= 2'(rnd());
    svc_i <= 1'b1;
    svc_ch_i <= ch;
    repeat (2) @(posedge clk_i);
    svc_i <= 1'b0;
    while (svc_busy_o !== 1'b0 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    @(posedge clk_i);
  endtask

  // ----
  // Checking
  // ----
  always @(negedge clk_i) begin
    logic [7:0] e;
    logic [23:0] t;
    if (unit_desc_valid_o === 1'b1) begin
      chk("rx_queue", 1, rxq.size() > 0);
      e = rxq.pop_front();
      chk("status", e[3:0], indicate_status_field_o);
      chk("drop", e[6], rx_drop_o);
      if (e[7]) chk("tag", e[5:4], unit_desc_tag_o);
    end
    if (part_valid_o === 1'b1 || abort_o === 1'b1) begin
      chk("tx_queue", 1, txq.size() > 0);
      t = txq.pop_front();
      chk("abort", t[23], abort_o);
      if (t[23] || t[22]) chk("exc", t[19:16], completion_report_descriptor_status_o);
      if (!t[23]) begin
        chk("ptag", t[21:20], part_o.tag);
        chk("size", 8'h10, part_o.size);
        chk("loc", t[15:8], part_o.loc[7:0]);
        chk("done", t[22], job_done_o);
        chk("fc", t[7:0], job_o.fc);
      end
    end
  end

  // ----
  // Sequence
  // ----
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, DSRC_CTRL_OFF, 32'h0);
    chk("ctrl_rst", DSRC_CTRL_RST, rd);
    for (int b = 0; b < 4; b++) begin
      {sort, flow} = 2'(b);
      wb(1'b1, DSRC_CTRL_OFF, {30'h0, sort, flow});
      repeat (64) begin
        x = rnd() & (rnd() | 32'h7f8000) & ((rnd() & rnd()) | 32'h7fffe0);
        rx(dsrc_rx_unit_t'(x[22:0]));
      end
      rx_valid_i <= 1'b0;
      @(posedge clk_i);
    end
    wb(1'b1, DSRC_QPTR_OFF + 8'h04, 32'h80);
    desc(0, TAG_FIRST, 8'h51, 4'h1, 4'h1);
    desc(1, TAG_MIDDLE, 8'hee, 4'h0, 4'h0);
    desc(2, TAG_LAST, 8'hee, 4'h0, 4'h0);
    desc(3, TAG_ONLY, 8'h52, 4'h0, 4'h1);
    desc(4, TAG_MIDDLE, 8'h53, 4'h1, 4'h1);
    desc(5, TAG_FIRST, 8'h54, 4'h1, 4'h1);
    desc(6, TAG_FIRST, 8'h55, 4'h1, 4'h1);
    desc(7, TAG_ONLY, 8'h56, 4'h1, 4'h0);
    desc(16, TAG_ONLY, 8'h57, 4'h2, 4'h1);
    ex({2'b00, TAG_FIRST}, EXC_NONE, 0, 8'h51);
    ex({2'b00, TAG_MIDDLE}, EXC_NONE, 1, 8'h51);
    ex({2'b01, TAG_LAST}, EXC_NONE, 2, 8'h51);
    ex(4'h8, EXC_REQ_CLASS, 3, 8'h0);
    ex(4'h8, EXC_NOT_FIRST, 4, 8'h0);
    ex({2'b00, TAG_FIRST}, EXC_NONE, 5, 8'h54);
    ex(4'h8, EXC_FIRST_OPEN, 6, 8'h0);
    ex(4'h8, EXC_CONF_CLASS, 7, 8'h0);
    ex({2'b01, TAG_ONLY}, EXC_NONE, 16, 8'h57);
    repeat (5) svc(1'b0);
    svc(1'b1);
    wb(1'b0, DSRC_QPTR_OFF, 32'h0);
    chk("qptr0", 32'h40, rd);
    wb(1'b0, DSRC_QPTR_OFF + 8'h04, 32'h0);
    chk("qptr1", 32'h88, rd);
    wb(1'b0, DSRC_STAT_OFF, 32'h0);
    chk("stat", {20'h0, EXC_CONF_CLASS, 8'(fcnt)}, rd);
    wb(1'b1, 8'h40, 32'hffff_ffff);
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, rd);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    {fcnt, flow, sort} = '0;
    thr = 2;
    @(posedge clk_i);
    wb(1'b1, DSRC_CTRL_OFF, 32'h0200);
    u = '0;
    u.frame_end = 1'b1;
    repeat (3) rx(u);
    rx_valid_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk("left", 0, rxq.size() + txq.size());
    test_done();
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    test_done();
  end
endmodule
